// ===== core/ocp_pkg.sv
`default_nettype none

package ocp_pkg;

  // Clock and on-time quantum
  localparam int CLK_NS  = 40;
  localparam int STEP_NS = 10;
  localparam int ON_INC  = CLK_NS / STEP_NS;

  // Startup and retry timing, in printed units
  localparam int CAL_US  = 350;
  localparam int PRE_US  = 400;
  localparam int SS_MS   = 14;
  localparam int WAIT_SS = 4;

  // Cycle counts, least times rounded up
  localparam int CAL_CYC  = (CAL_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int PRE_CYC  = (PRE_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int SS_CYC   = (SS_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int WAIT_CYC = WAIT_SS * SS_CYC;

  // Widths
  localparam int TMR_W = 24;
  localparam int CNT_W = 16;
  localparam int CODE_W = 6;
  localparam int REF_W  = 7;

  // Trip reference converter: 63 steps of 6.51 mV, 403 mV top
  localparam int STEP_UV = 6510;
  localparam int TOP_MV  = 403;
  localparam logic [CODE_W-1:0] CODE_ZERO = 6'h00;
  localparam logic [CODE_W-1:0] CODE_ONE  = 6'h01;
  localparam logic [CODE_W-1:0] CODE_MAX  = 6'h3F;
  localparam logic [CODE_W-1:0] CODE_DEAD = 6'h0A;
  localparam logic [REF_W-1:0]  REF_ZERO  = 7'h00;
  localparam logic [TMR_W-1:0]  TMR_ZERO  = 24'h00_0000;
  localparam logic [TMR_W-1:0]  TMR_ONE   = 24'h00_0001;
  localparam logic [TMR_W-1:0]  CODE_SPAN = 24'h00_0040;
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_INC   = 16'h0004;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 16'hFFFF;

  // Sequencer states
  typedef enum logic [7:0] {
    ST_IDLE   = 8'b0000_0001,
    ST_PRE    = 8'b0000_0010,
    ST_SOFT   = 8'b0000_0100,
    ST_RUN    = 8'b0000_1000,
    ST_FINISH = 8'b0001_0000,
    ST_HWAIT  = 8'b0010_0000,
    ST_HALF   = 8'b0100_0000,
    ST_REST   = 8'b1000_0000
  } state_e;

endpackage

`default_nettype wire

// ===== core/ocp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface ocp_if;
  logic gateOn;
  logic windowOpen;
  logic halfDone;

  modport ctrl  (output gateOn, input windowOpen, input halfDone);
  modport meter (input gateOn, output windowOpen, output halfDone);
endinterface

`default_nettype wire

// ===== core/on_time_window.sv
`timescale 1ns/1ps
`default_nettype none

module on_time_window #(
  parameter int CNT_W = ocp_pkg::CNT_W
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Gate and window
  ocp_if.meter     win
);

  logic [CNT_W-1:0] count_r, count_nxt;
  logic [CNT_W-1:0] limit_r, limit_nxt;
  logic [CNT_W-1:0] half_r,  half_nxt;
  logic             gateD_r, gateD_nxt;
  logic             rise;
  logic             fall;
  logic [CNT_W-1:0] elapsed;

  // Counter constants at this module's width
  localparam logic [CNT_W-1:0] CNT_WIDTH_ZERO = CNT_W'(ocp_pkg::CNT_ZERO);
  localparam logic [CNT_W-1:0] CNT_STEP       = CNT_W'(ocp_pkg::CNT_INC);
  localparam logic [CNT_W-1:0] CNT_HOLD       =
    CNT_W'(ocp_pkg::CNT_MAX - ocp_pkg::CNT_INC);

  // Edges of the upper gate and time elapsed in this pulse
  assign rise    = win.gateOn & ~gateD_r;
  assign fall    = ~win.gateOn & gateD_r;
  assign elapsed = rise ? CNT_WIDTH_ZERO : count_r;

  // Window only below three quarters of the prior on-time
  assign win.windowOpen = win.gateOn & (elapsed < limit_r); // [R8] [R1]
  // This cycle's step already counts, so the pulse is not one step long
  assign win.halfDone   = win.gateOn & (elapsed + CNT_STEP >= half_r); // [R13]

  // Counter in 10 ns units, restarted at each pulse start
  always_comb begin
    count_nxt = count_r;
    limit_nxt = limit_r;
    half_nxt  = half_r;
    gateD_nxt = win.gateOn;
    if (rise) begin
      count_nxt = CNT_W'(ocp_pkg::CNT_INC); // [R18]
    end else if (win.gateOn && count_r <= CNT_HOLD) begin
      count_nxt = count_r + CNT_W'(ocp_pkg::CNT_INC); // [R9] [R18]
    end
    // Very long pulses hold at the top instead of wrapping
    if (fall) begin
      limit_nxt = count_r - (count_r >> 2); // [R9]
      half_nxt  = count_r >> 1;
    end
  end

  // First pulse after reset has a closed window, no history yet
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      count_r <= CNT_WIDTH_ZERO;
      limit_r <= CNT_WIDTH_ZERO;
      half_r  <= CNT_WIDTH_ZERO;
      gateD_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      limit_r <= limit_nxt;
      half_r  <= half_nxt;
      gateD_r <= gateD_nxt;
    end
  end

endmodule

`default_nettype wire

// ===== core/current_limit_sequencer.sv
// What this block does
// [R1] Sense upper switch only while it conducts
// [R2] Calibrate trip level in 350 us startup
// [R3] Hold calibrated level as 6-bit trip code
// [R4] Reference: 63 steps, 6.51 mV, 403 mV top
// [R5] Step counter until comparator crosses, then freeze
// [R6] Set level above range means no limit
// [R7] Codes zero through ten give zero threshold
// [R8] Sense only up to three-quarter on-time
// [R9] Count on-time in 10 ns; keep 3/4
// [R10] Flag fault when sense exceeds reference in window
// [R11] Double trip value during soft-start
// [R12] Restore undoubled value after soft-start
// [R13] After trip finish cycle, then half pulse
// [R14] Both off four soft-starts, then retry
// [R15] Soft-start lasts 14 ms, the wait unit
// [R16] 400 us pre-start before soft-start
// [R17] No crossing: stop at top, no limit
// [R18] One 10 ns timebase; counter restarts per pulse
`timescale 1ns/1ps
`default_nettype none

module current_limit_sequencer #(
  parameter logic [23:0] CAL_CYCLES  = 24'(ocp_pkg::CAL_CYC),
  parameter logic [23:0] PRE_CYCLES  = 24'(ocp_pkg::PRE_CYC),
  parameter logic [23:0] SS_CYCLES   = 24'(ocp_pkg::SS_CYC),
  parameter logic [23:0] WAIT_CYCLES = 24'(ocp_pkg::WAIT_CYC)
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  // Control from the converter core
  input  wire logic                      enable,
  input  wire logic                      pwmHigh,
  // Analog comparators
  input  wire logic                      calCompAbove,
  input  wire logic                      senseCompTrip,
  // Power stage drive
  output logic                           upperGate,
  output logic                           lowerGate,
  // Reference converter and status
  output logic [ocp_pkg::CODE_W-1:0]     calCode,
  output logic [ocp_pkg::REF_W-1:0]      tripRefCode,
  output logic                           limitEnabled,
  output logic                           softStartActive,
  output logic                           overcurrentTrip,
  output logic                           restartWait
);

  // Step period: 64 codes spread over the calibration time
  localparam logic [23:0] STEP_LAST =
    CAL_CYCLES / ocp_pkg::CODE_SPAN - ocp_pkg::TMR_ONE;

  ocp_pkg::state_e             state_r, state_nxt;
  logic [ocp_pkg::TMR_W-1:0]   timer_r, timer_nxt;
  logic [ocp_pkg::TMR_W-1:0]   stepCnt_r, stepCnt_nxt;
  logic [ocp_pkg::CODE_W-1:0]  code_r, code_nxt;
  logic                        calDone_r, calDone_nxt;
  logic                        noLimit_r, noLimit_nxt;
  logic                        upper_r, upper_nxt;
  logic                        lower_r, lower_nxt;
  logic [ocp_pkg::REF_W-1:0]   ref_r, ref_nxt;
  logic                        trip_r, trip_nxt;
  logic                        softStart_r, softStart_nxt;
  logic                        restWait_r, restWait_nxt;
  logic                        limitOn_r, limitOn_nxt;
  logic [ocp_pkg::CODE_W-1:0]  effCode;
  logic                        tripNow;

  ocp_if win ();

  assign win.gateOn = upper_r;

  on_time_window #(
    .CNT_W (ocp_pkg::CNT_W)
  ) u_window (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .win     (win)
  );

  // Low codes collapse to a zero threshold
  assign effCode = (code_r <= ocp_pkg::CODE_DEAD) ? ocp_pkg::CODE_ZERO
                                                  : code_r; // [R7]

  // Trip only inside the window and only with a limit set
  assign tripNow = ~noLimit_r & win.windowOpen & senseCompTrip; // [R10] [R6]

  // Sequencer next state
  always_comb begin
    state_nxt   = state_r;
    timer_nxt   = timer_r + ocp_pkg::TMR_ONE;
    stepCnt_nxt = stepCnt_r;
    code_nxt    = code_r;
    calDone_nxt = calDone_r;
    noLimit_nxt = noLimit_r;
    upper_nxt   = 1'b0;
    lower_nxt   = 1'b0;
    trip_nxt    = 1'b0;
    unique case (state_r)
      ocp_pkg::ST_IDLE: begin
        timer_nxt = ocp_pkg::TMR_ZERO;
        if (enable) begin
          state_nxt   = ocp_pkg::ST_PRE; // [R16]
          stepCnt_nxt = ocp_pkg::TMR_ZERO;
          code_nxt    = ocp_pkg::CODE_ZERO;
          calDone_nxt = 1'b0;
          noLimit_nxt = 1'b0;
        end
      end
      ocp_pkg::ST_PRE: begin
        // Stepping ends inside the calibration time
        stepCnt_nxt = stepCnt_r + ocp_pkg::TMR_ONE;
        if (stepCnt_r == STEP_LAST) begin
          stepCnt_nxt = ocp_pkg::TMR_ZERO;
          if (!calDone_r && timer_r < CAL_CYCLES) begin // [R2]
            if (calCompAbove) begin
              calDone_nxt = 1'b1; // [R5] [R3]
            end else if (code_r == ocp_pkg::CODE_MAX) begin
              calDone_nxt = 1'b1; // [R17]
              noLimit_nxt = 1'b1; // [R6]
            end else begin
              code_nxt = code_r + ocp_pkg::CODE_ONE; // [R5] [R4]
            end
          end
        end
        if (timer_r == PRE_CYCLES - ocp_pkg::TMR_ONE) begin
          // Unfinished stepping counts as out of range
          if (!calDone_r) begin
            calDone_nxt = 1'b1;
            noLimit_nxt = 1'b1; // [R17]
          end
          state_nxt = ocp_pkg::ST_SOFT; // [R16]
          timer_nxt = ocp_pkg::TMR_ZERO;
        end
      end
      ocp_pkg::ST_SOFT, ocp_pkg::ST_RUN: begin
        upper_nxt = pwmHigh;
        lower_nxt = ~pwmHigh;
        if (state_r == ocp_pkg::ST_SOFT &&
            timer_r == SS_CYCLES - ocp_pkg::TMR_ONE) begin
          state_nxt = ocp_pkg::ST_RUN; // [R15] [R12]
        end
        if (tripNow) begin
          trip_nxt  = 1'b1; // [R10]
          state_nxt = ocp_pkg::ST_FINISH; // [R13]
        end
      end
      ocp_pkg::ST_FINISH: begin
        // Let the present pulse run to its natural end
        upper_nxt = pwmHigh; // [R13]
        lower_nxt = ~pwmHigh;
        if (!pwmHigh) begin
          state_nxt = ocp_pkg::ST_HWAIT;
        end
      end
      ocp_pkg::ST_HWAIT: begin
        lower_nxt = 1'b1;
        if (pwmHigh) begin
          state_nxt = ocp_pkg::ST_HALF; // [R13]
          upper_nxt = 1'b1;
          lower_nxt = 1'b0;
        end
      end
      ocp_pkg::ST_HALF: begin
        upper_nxt = 1'b1;
        if (win.halfDone) begin
          state_nxt = ocp_pkg::ST_REST; // [R13]
          upper_nxt = 1'b0;
          timer_nxt = ocp_pkg::TMR_ZERO;
        end
      end
      ocp_pkg::ST_REST: begin
        // Both switches stay off for the whole wait
        if (timer_r == WAIT_CYCLES - ocp_pkg::TMR_ONE) begin
          state_nxt = ocp_pkg::ST_SOFT; // [R14]
          timer_nxt = ocp_pkg::TMR_ZERO;
        end
      end
      default: begin
        state_nxt = ocp_pkg::ST_IDLE;
      end
    endcase
    // Disable drops everything back to standby
    if (!enable) begin
      state_nxt = ocp_pkg::ST_IDLE;
      upper_nxt = 1'b0;
      lower_nxt = 1'b0;
      trip_nxt  = 1'b0;
    end
  end

  // Status flags registered; reference doubled in soft-start for inrush
  always_comb begin
    softStart_nxt = (state_nxt == ocp_pkg::ST_SOFT);
    restWait_nxt  = (state_nxt == ocp_pkg::ST_REST); // [R14]
    limitOn_nxt   = ~noLimit_nxt; // [R6]
    if (state_nxt == ocp_pkg::ST_SOFT) begin
      ref_nxt = {effCode, 1'b0}; // [R11]
    end else begin
      ref_nxt = {1'b0, effCode}; // [R12]
    end
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r   <= ocp_pkg::ST_IDLE;
      timer_r   <= ocp_pkg::TMR_ZERO;
      stepCnt_r <= ocp_pkg::TMR_ZERO;
      code_r    <= ocp_pkg::CODE_ZERO;
      calDone_r <= 1'b0;
      noLimit_r <= 1'b0;
      upper_r   <= 1'b0;
      lower_r   <= 1'b0;
      ref_r     <= ocp_pkg::REF_ZERO;
      trip_r    <= 1'b0;
      softStart_r <= 1'b0;
      restWait_r  <= 1'b0;
      limitOn_r   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      timer_r   <= timer_nxt;
      stepCnt_r <= stepCnt_nxt;
      code_r    <= code_nxt;
      calDone_r <= calDone_nxt;
      noLimit_r <= noLimit_nxt;
      upper_r   <= upper_nxt;
      lower_r   <= lower_nxt;
      ref_r     <= ref_nxt;
      trip_r    <= trip_nxt;
      softStart_r <= softStart_nxt;
      restWait_r  <= restWait_nxt;
      limitOn_r   <= limitOn_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign upperGate       = upper_r;
  assign lowerGate       = lower_r;
  assign calCode         = code_r;
  assign tripRefCode     = ref_r;
  assign limitEnabled    = limitOn_r;
  assign softStartActive = softStart_r;
  assign overcurrentTrip = trip_r;
  assign restartWait     = restWait_r;

endmodule

`default_nettype wire

// ===== testbench/clseq_props.sv
`timescale 1ns/1ps
`default_nettype none

module clseq_props (
  // Clock, reset and inputs
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       enable,
  input wire logic       senseCompTrip,
  // Outputs watched
  input wire logic       upperGate,
  input wire logic       lowerGate,
  input wire logic [5:0] calCode,
  input wire logic [6:0] tripRefCode,
  input wire logic       limitEnabled,
  input wire logic       softStartActive,
  input wire logic       overcurrentTrip,
  input wire logic       restartWait
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Settled soft-start with a live code
  sequence s_steady;
    softStartActive && $past(softStartActive) && calCode > 6'h0A;
  endsequence
  // Retry wait running out while still enabled
  sequence s_waitEnd;
    restartWait ##1 (!restartWait && enable && $past(enable));
  endsequence

  a_reset_outputs: assert property ($past(sys_rst) |-> !upperGate
    && !lowerGate && limitEnabled && !overcurrentTrip && !restartWait)
    else $error("outputs wrong after reset");
  a_sense_gated: assert property (overcurrentTrip |->
    $past(senseCompTrip && upperGate) && limitEnabled)
    else $error("trip without conducting sense");
  a_trip_single: assert property (overcurrentTrip |=>
    !overcurrentTrip)
    else $error("trip flag longer than one cycle");
  a_no_limit: assert property (!limitEnabled |-> !overcurrentTrip)
    else $error("trip while limit disabled");
  a_cal_step: assert property ($changed(calCode) |->
    calCode == $past(calCode) + 6'h01 || calCode == 6'h00)
    else $error("calibration code jumped");
  a_cal_frozen: assert property (softStartActive |-> $stable(calCode))
    else $error("trip code moved in soft-start");
  a_dead_zone: assert property ($stable(calCode) && calCode <= 6'h0A
    && !$past(sys_rst) |-> tripRefCode == 7'h00)
    else $error("low code gives nonzero reference");
  a_soft_double: assert property (s_steady |->
    tripRefCode == {calCode, 1'b0})
    else $error("reference not doubled in soft-start");
  a_soft_restore: assert property ($fell(softStartActive) && enable
    && $past(enable) && calCode > 6'h0A |-> tripRefCode == {1'b0, calCode})
    else $error("reference not restored after soft-start");
  a_wait_off: assert property (restartWait && $past(restartWait) |->
    !upperGate && !lowerGate)
    else $error("switch on during retry wait");
  a_retry_soft: assert property (s_waitEnd |-> softStartActive)
    else $error("no soft-start after retry wait");
endmodule

bind current_limit_sequencer clseq_props props_u (.mclk, .sys_rst,
  .enable, .senseCompTrip, .upperGate, .lowerGate, .calCode,
  .tripRefCode, .limitEnabled, .softStartActive, .overcurrentTrip,
  .restartWait);

`default_nettype wire

// ===== testbench/power_stage_model.sv
`timescale 1ns/1ps
`default_nettype none

module power_stage_model (
  // Clock
  input  wire logic       mclk,
  // Stage drive and references
  input  wire logic       upperGate,
  input  wire logic [5:0] calCode,
  input  wire logic [6:0] tripRefCode,
  // Operating point from the bench
  input  wire logic [5:0] setCode,
  input  wire logic [6:0] load,
  // Comparators
  output logic            calCompAbove,
  output logic            senseCompTrip
);
  logic junk_r = 1'b0;

  // Drop reading is noise while the switch is open
  always_ff @(posedge mclk) junk_r <= !junk_r;
  // Level 63 is never passed, so the code runs to the top
  assign calCompAbove = calCode > setCode;
  assign senseCompTrip = upperGate ? load > tripRefCode : junk_r;
endmodule

`default_nettype wire

// ===== testbench/current_limit_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none

module current_limit_sequencer_test;
  localparam logic [23:0] PRE_C  = 24'h00_02BC;
  localparam logic [23:0] WAIT_C = 24'h00_0320;
  logic       mclk, sys_rst, enable, pwmHigh, calCompAbove;
  logic       senseCompTrip, upperGate, lowerGate, limitEnabled;
  logic       softStartActive, overcurrentTrip, restartWait;
  logic [5:0] calCode, setCode;
  logic [6:0] tripRefCode, load;
  int         err_count = 0, n_compared = 0, trips = 0, rests = 0;

  current_limit_sequencer #(
    .CAL_CYCLES (24'h00_0280), .PRE_CYCLES (PRE_C),
    .SS_CYCLES  (24'h00_00C8), .WAIT_CYCLES(WAIT_C)
  ) dut_u (.mclk, .sys_rst, .enable, .pwmHigh, .calCompAbove,
    .senseCompTrip, .upperGate, .lowerGate, .calCode, .tripRefCode,
    .limitEnabled, .softStartActive, .overcurrentTrip, .restartWait);

  power_stage_model stage_u (.mclk, .upperGate, .calCode, .tripRefCode,
    .setCode, .load, .calCompAbove, .senseCompTrip);

  // Clock and event counters
  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (overcurrentTrip === 1'b1) trips++;
    if (restartWait === 1'b1) rests++;
  end

  task automatic final_report;
    $display("Compared %0d, errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: flag %b want %b", $time, got, exp);
    end
  endtask

  task automatic chk_num(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %0d want %0d", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Bounded wait; running out ends the run
  task automatic wait_on(ref logic sig, input logic lvl, output int n);
    n = 0;
    while (sig !== lvl) begin
      tick(1);
      n++;
      if (n > 3000) begin
        err_count++;
        $display("CHECK FAILED at %0t: wait ran out", $time);
        final_report;
      end
    end
  endtask

  // Wish the upper switch on, then four cycles off
  task automatic pulse(input int on);
    pwmHigh = 1'b1;
    tick(on);
    pwmHigh = 1'b0;
    tick(4);
  endtask

  function automatic logic [6:0] exp_ref(input logic [5:0] c,
                                         input logic dbl);
    if (c <= 6'h0A) return 7'h00;
    return dbl ? {c, 1'b0} : {1'b0, c};
  endfunction

  // One enable: calibrate, soft-start, run; trip and retry only when a limit is set
  task automatic run_case(input logic [5:0] s);
    logic [5:0] c;
    int         n, t0, h;
    c = (s == 6'h3F) ? s : s + 6'h01;
    setCode = s;
    load = 7'h00;
    enable = 1'b1;
    wait_on(softStartActive, 1'b1, n);
    chk_num(24'(n), PRE_C + 24'h00_0001);
    chk_num(24'(calCode), 24'(c));
    chk_flag(limitEnabled, s != 6'h3F);
    chk_num(24'(tripRefCode), 24'(exp_ref(c, 1'b1)));
    n = 0;
    while (softStartActive === 1'b1 && n < 100) begin
      pulse(4 + $urandom_range(7));
      n++;
    end
    chk_flag(softStartActive, 1'b0);
    chk_num(24'(tripRefCode), 24'(exp_ref(c, 1'b0)));
    // Overdrive only after the three-quarter mark
    pulse(8);
    t0 = trips;
    pwmHigh = 1'b1;
    tick(7);
    load = 7'h7F;
    tick(2);
    pwmHigh = 1'b0;
    load = 7'h00;
    tick(4);
    chk_num(24'(trips - t0), 24'h00_0000);
    // Overdrive from the start of the pulse
    load = {1'b0, c} + 7'h01;
    pulse(8);
    chk_num(24'(trips - t0), 24'(s != 6'h3F));
    if (s != 6'h3F) begin
      rests = 0;
      h = 0;
      pwmHigh = 1'b1;
      repeat (20) begin
        tick(1);
        h += int'(upperGate === 1'b1);
      end
      // Tripped pulse ran 8 cycles, so the trailing pulse runs half
      chk_num(24'(h), 24'(8 / 2));
      // Both off in the wait although the wish stays high
      chk_flag(upperGate, 1'b0);
      chk_flag(lowerGate, 1'b0);
      wait_on(softStartActive, 1'b1, n);
      chk_num(24'(rests), WAIT_C);
      chk_num(24'(calCode), 24'(c));
      chk_num(24'(tripRefCode), 24'(exp_ref(c, 1'b1)));
    end
    enable = 1'b0;
    pwmHigh = 1'b0;
    load = 7'h00;
    tick(3);
  endtask

  initial begin
    mclk = 1'b0;
    sys_rst = 1'b1;
    enable = 1'b0;
    pwmHigh = 1'b0;
    setCode = 6'h00;
    load = 7'h00;
    void'($urandom(32'h1E1C_9B8C));
    tick(10);
    sys_rst = 1'b0;
    chk_flag(limitEnabled, 1'b1);
    run_case(6'h0B + 6'($urandom_range(50)));
    run_case(6'h09);
    run_case(6'h3F);
    final_report;
  end
endmodule

`default_nettype wire
